// File: logic/usp_port.v
`timescale 1ns/1ps
`include "usp_defines.vh"
// Function
// - mode 00: one shared pin, half duplex, start + 8 data + stop
// - mode 01: separate transmit and receive pins, start + 8 data + stop
// - mode 10: one shared pin, half duplex, start + 9 data + stop
// - mode 11: separate pins, start + 9 data + stop
// - data write starts a frame; transmit flag sets after the stop bit
// - nine-bit modes send the ninth transmit bit with the data byte
// - receive only while enabled; flag and byte after data and stop
// - nine-bit modes keep the ninth received bit in the control field
// - top two control bits select the frame mode
// - control bit selects single or multi device communication
// - flags read as pending; write 0 clears, write 1 raises the event
// - data address holds separate transmit and receive buffers
// - bit rate is clock / (16 / (1 + double)) / (divisor + 1)
// - separate bits invert the receive input and transmit output
module usp_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        rxd_in,
  output reg         rxd_out,
  output reg         rxd_oe,
  output reg         txd_out,
  output wire        irq
);
  // ************************************************************
  // state encodings
  // ************************************************************
  localparam RX_IDLE  = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA  = 2'b10;
  localparam RX_STOP  = 2'b11;

  reg  [7:0]  control;
  reg  [15:0] divisor;
  reg  [1:0]  int_status;
  reg  [1:0]  int_mask;
  reg  [7:0]  rx_buffer;
  reg  [10:0] tx_shift;
  reg  [3:0]  tx_left;
  reg  [4:0]  tx_sub;
  reg         tx_busy;
  reg  [1:0]  rx_state;
  reg  [4:0]  rx_sub;
  reg  [3:0]  rx_count;
  reg  [8:0]  rx_shift;
  reg         rx_prev;
  reg  [31:0] next_prdata;
  reg         next_slverr;
  reg         tx_done;
  reg         rx_done;
  reg         rx_ninth;
  wire        tick;
  wire        rxd_sync;
  wire        rx_line;
  wire [1:0]  mode;
  wire        nine_bit;
  wire        single_wire;
  wire [4:0]  ovs;
  wire [4:0]  ovs_half;
  wire        setup_ph;
  wire        acc_wr;
  wire        acc_rd;
  wire        rx_allowed;
  wire        rx_accept;
  wire        tx_bit;

  assign mode        = control[`USP_CTL_MODE_HI:`USP_CTL_MODE_LO];
  assign nine_bit    = mode[1];
  assign single_wire = ~mode[0];
  // doubling halves the oversample count, doubling the bit rate
  assign ovs         = divisor[`USP_DIV_DOUBLE] ? `USP_OVS_DOUBLE : `USP_OVS_NORMAL;
  assign ovs_half    = {1'b0, ovs[4:1]};

  // ************************************************************
  // bus handshake
  // ************************************************************
  // every access completes in its first access cycle unless frozen
  assign pready   = ce;
  assign setup_ph = ce & psel & ~penable;
  assign acc_wr   = ce & psel & penable & pwrite;
  assign acc_rd   = ce & psel & penable & ~pwrite;

  // ************************************************************
  // baud tick and input synchroniser
  // ************************************************************
  // the divisor's top bits carry the doubler and the line inversions, not the count
  usp_tick #(
    .DIV_W (12)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .divisor (divisor[`USP_DIV_VALUE_HI:0]),
    .tick    (tick)
  );

  // the shared or receive pin arrives from outside the clock domain
  usp_sync #(
    .RESET_VAL (1'b1)
  ) u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (rxd_in),
    .q       (rxd_sync)
  );

  assign rx_line = rxd_sync ^ divisor[`USP_DIV_RX_INV];

  // ************************************************************
  // read data, captured in the setup cycle
  // ************************************************************
  // a status bit set during the access cycle is neither returned nor
  // cleared by that read, so no event is lost to a racing read
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `USP_ADDR_CONTROL:    next_prdata = {24'h00_0000, control};
      `USP_ADDR_DATA:       next_prdata = {24'h00_0000, rx_buffer};
      `USP_ADDR_DIVISOR:    next_prdata = {16'h0000, divisor[15:13], 1'b0, divisor[11:0]};
      `USP_ADDR_INT_STATUS: next_prdata = {30'h0000_0000, int_status};
      `USP_ADDR_INT_MASK:   next_prdata = {30'h0000_0000, int_mask};
      default:              next_slverr = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end
  end

  // ************************************************************
  // control, divisor and interrupt registers
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control    <= `USP_RST_CONTROL;
      divisor    <= `USP_RST_DIVISOR;
      int_mask   <= `USP_RST_INT_MASK;
      int_status <= 2'h0;
    end else if (ce) begin
      if (acc_wr && paddr == `USP_ADDR_CONTROL && pstrb[0]) begin
        control[7:3] <= pwdata[7:3];
        control[`USP_CTL_RB8] <= rx_done ? rx_ninth : pwdata[`USP_CTL_RB8];
        // a hardware set in the same cycle beats a written zero
        control[`USP_CTL_TI] <= pwdata[`USP_CTL_TI] | tx_done;
        control[`USP_CTL_RI] <= pwdata[`USP_CTL_RI] | rx_done;
      end else begin
        if (tx_done)
          control[`USP_CTL_TI] <= 1'b1;
        if (rx_done) begin
          control[`USP_CTL_RI]  <= 1'b1;
          control[`USP_CTL_RB8] <= rx_ninth;
        end
      end
      if (acc_wr && paddr == `USP_ADDR_DIVISOR) begin
        if (pstrb[0])
          divisor[7:0] <= pwdata[7:0];
        if (pstrb[1])
          divisor[15:8] <= {pwdata[15:13], 1'b0, pwdata[11:8]};
      end
      if (acc_wr && paddr == `USP_ADDR_INT_MASK && pstrb[0])
        int_mask <= pwdata[1:0];
      // read clears only the bits that the reader saw; new events still set
      int_status <= (int_status & ~((acc_rd && paddr == `USP_ADDR_INT_STATUS) ? prdata[1:0] : 2'h0))
                    | {tx_done | (acc_wr && paddr == `USP_ADDR_CONTROL && pstrb[0] && pwdata[`USP_CTL_TI]),
                       rx_done | (acc_wr && paddr == `USP_ADDR_CONTROL && pstrb[0] && pwdata[`USP_CTL_RI])};
    end
  end

  assign irq = |(int_status & int_mask);

  // ************************************************************
  // transmitter
  // ************************************************************
  // the prescaler runs free and is not restarted per frame, so the
  // start bit may be short by up to one divisor period; with a divisor
  // of zero every bit is exactly one oversample count of clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= 11'h7FF;
      tx_left  <= 4'h0;
      tx_sub   <= 5'h00;
      tx_busy  <= 1'b0;
      tx_done  <= 1'b0;
    end else if (ce) begin
      tx_done <= 1'b0;
      if (!tx_busy) begin
        // a write to the transmit buffer while a frame runs is dropped
        if (acc_wr && paddr == `USP_ADDR_DATA && pstrb[0]) begin
          tx_busy <= 1'b1;
          tx_sub  <= 5'h00;
          if (nine_bit) begin
            tx_shift <= {1'b1, control[`USP_CTL_TB8], pwdata[7:0], 1'b0};
            tx_left  <= `USP_BITS_LONG;
          end else begin
            tx_shift <= {2'b11, pwdata[7:0], 1'b0};
            tx_left  <= `USP_BITS_SHORT;
          end
        end
      end else if (tick) begin
        if (tx_sub == ovs - 5'h01) begin
          tx_sub   <= 5'h00;
          tx_shift <= {1'b1, tx_shift[10:1]};
          if (tx_left == 4'h1) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
          end
          tx_left <= tx_left - 4'h1;
        end else begin
          tx_sub <= tx_sub + 5'h01;
        end
      end
    end
  end

  assign tx_bit = tx_busy ? tx_shift[0] : 1'b1;

  // ************************************************************
  // pin drivers
  // ************************************************************
  // pins are registered: each shift shows on the pin one clock later, and the
  // shared pin is released only after the stop bit has stood its full time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else if (ce) begin
      if (single_wire) begin
        txd_out <= 1'b1 ^ divisor[`USP_DIV_TX_INV];
        rxd_out <= tx_bit ^ divisor[`USP_DIV_TX_INV];
        rxd_oe  <= tx_busy;
      end else begin
        txd_out <= tx_bit ^ divisor[`USP_DIV_TX_INV];
        rxd_out <= 1'b1;
        rxd_oe  <= 1'b0;
      end
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  // on a shared pin the port would hear its own frame, so it stops listening
  assign rx_allowed = control[`USP_CTL_REN] & ~(single_wire & tx_busy);
  // multi-device: a nine-bit frame with ninth bit low raises no flag
  assign rx_accept  = ~(control[`USP_CTL_MULTI] & nine_bit & ~rx_shift[8]);
  // rx_prev resets to the idle level, so leaving reset never looks like a start edge

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state  <= RX_IDLE;
      rx_sub    <= 5'h00;
      rx_count  <= 4'h0;
      rx_shift  <= 9'h000;
      rx_prev   <= 1'b1;
      rx_buffer <= 8'h00;
      rx_done   <= 1'b0;
      rx_ninth  <= 1'b0;
    end else if (ce) begin
      rx_prev <= rx_line;
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_allowed && rx_prev && !rx_line) begin
            rx_state <= RX_START;
            rx_sub   <= 5'h00;
          end
        end
        RX_START: begin
          if (!rx_allowed) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            if (rx_sub == ovs_half - 5'h01) begin
              rx_sub   <= 5'h00;
              rx_count <= 4'h0;
              // a glitch shorter than half a bit is not a start bit
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
            end else begin
              rx_sub <= rx_sub + 5'h01;
            end
          end
        end
        RX_DATA: begin
          if (!rx_allowed) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            if (rx_sub == ovs - 5'h01) begin
              rx_sub <= 5'h00;
              if (nine_bit)
                rx_shift <= {rx_line, rx_shift[8:1]};
              else
                // eight-bit frames fill [8:1], leaving [0] clear for the next frame
                rx_shift <= {rx_line, rx_shift[8:2], 1'b0};
              rx_count <= rx_count + 4'h1;
              if (rx_count == (nine_bit ? 4'h8 : 4'h7))
                rx_state <= RX_STOP;
            end else begin
              rx_sub <= rx_sub + 5'h01;
            end
          end
        end
        RX_STOP: begin
          if (!rx_allowed) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            if (rx_sub == ovs - 5'h01) begin
              rx_sub   <= 5'h00;
              rx_state <= RX_IDLE;
              // stop level is not checked: no framing error is reported
              if (rx_accept) begin
                rx_buffer <= nine_bit ? rx_shift[7:0] : rx_shift[8:1];
                rx_ninth  <= nine_bit ? rx_shift[8] : control[`USP_CTL_RB8];
                rx_done   <= 1'b1;
              end
            end else begin
              rx_sub <= rx_sub + 5'h01;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
endmodule // usp_port

// File: logic/usp_sync.v
`timescale 1ns/1ps
// ************************************************************
// two-flop synchroniser for a pin input
// ************************************************************
module usp_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire d,
  output reg  q
);
  reg meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // usp_sync

// File: logic/usp_tick.v
`timescale 1ns/1ps
// ************************************************************
// divisor prescaler: one tick every (divisor + 1) clocks
// ************************************************************
module usp_tick #(
  parameter DIV_W = 12
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  input  wire [DIV_W-1:0] divisor,
  output reg              tick
);
  reg [DIV_W-1:0] count;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {DIV_W{1'b0}};
      tick  <= 1'b0;
    end else if (ce) begin
      // >= guards against a divisor lowered below the running count
      if (count >= divisor) begin
        count <= {DIV_W{1'b0}};
        tick  <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick  <= 1'b0;
      end
    end
  end
endmodule // usp_tick

// File: shared/usp_defines.vh
`ifndef USP_DEFINES_VH
`define USP_DEFINES_VH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define USP_IDX_CONTROL     8'h98
`define USP_IDX_DATA        8'h99
`define USP_IDX_DIVISOR     8'h9A
`define USP_IDX_INT_STATUS  8'h9C
`define USP_IDX_INT_MASK    8'h9D
`define USP_ADDR_CONTROL    12'h260
`define USP_ADDR_DATA       12'h264
`define USP_ADDR_DIVISOR    12'h268
`define USP_ADDR_INT_STATUS 12'h270
`define USP_ADDR_INT_MASK   12'h274
// ************************************************************
// field positions
// ************************************************************
`define USP_CTL_MODE_HI     7
`define USP_CTL_MODE_LO     6
`define USP_CTL_MULTI       5
`define USP_CTL_REN         4
`define USP_CTL_TB8         3
`define USP_CTL_RB8         2
`define USP_CTL_TI          1
`define USP_CTL_RI          0
`define USP_DIV_DOUBLE      15
`define USP_DIV_RX_INV      14
`define USP_DIV_TX_INV      13
`define USP_DIV_VALUE_HI    11
// ************************************************************
// reset values and timing counts
// ************************************************************
`define USP_RST_CONTROL     8'h00
`define USP_RST_DIVISOR     16'h0081
`define USP_RST_INT_MASK    2'h0
`define USP_OVS_NORMAL      5'h10
`define USP_OVS_DOUBLE      5'h08
`define USP_BITS_SHORT      4'hA
`define USP_BITS_LONG       4'hB
`endif

// File: verification/usp_node.sv
`timescale 1ns/1ps
// ************************************************************
// remote serial node
// ************************************************************
module usp_node (
  input  wire pclk,
  input  wire line_in,
  output reg  line_drv
);
  integer   bclk    = 16;
  integer   nbits   = 8;
  integer   n_got   = 0;
  reg       sending = 1'b0;
  reg [8:0] got     = 9'h000;
  initial line_drv = 1'b1;
  // a low gone again by half a bit is a glitch from a polarity change, not a start bit
  always begin : rx
    integer i;
    @(negedge line_in);
    repeat (bclk / 2) @(posedge pclk);
    if (!sending && !line_in) begin
      for (i = 0; i < nbits; i = i + 1) begin
        repeat (bclk) @(posedge pclk);
        got[i] = line_in;
      end
      repeat (bclk) @(posedge pclk);
      if (line_in)
        n_got = n_got + 1;
    end
  end
  task send(input [8:0] v, input integer n);
    integer i;
    begin
      sending = 1'b1;
      line_drv <= 1'b0;
      repeat (bclk) @(posedge pclk);
      for (i = 0; i < n; i = i + 1) begin
        line_drv <= v[i];
        repeat (bclk) @(posedge pclk);
      end
      line_drv <= 1'b1;
      repeat (bclk) @(posedge pclk);
      sending = 1'b0;
    end
  endtask
endmodule // usp_node

// File: verification/usp_port_chk.sv
`timescale 1ns/1ps
`include "usp_defines.vh"
// ************************************************************
// port checker
// ************************************************************
module usp_port_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire        rxd_out,
  input wire        rxd_oe,
  input wire        txd_out,
  input wire        irq
);
  reg  [1:0]  mode;
  reg         txinv;
  reg         dbl;
  reg  [11:0] div;
  reg  [15:0] low_run;
  wire        acc = psel & penable & ce;
  wire        wr  = acc & pwrite;
  wire        mapped = paddr == `USP_ADDR_CONTROL || paddr == `USP_ADDR_DATA || paddr == `USP_ADDR_DIVISOR
                       || paddr == `USP_ADDR_INT_STATUS || paddr == `USP_ADDR_INT_MASK;
  wire [15:0] bt = (dbl ? 16'h0008 : 16'h0010) * ({4'h0, div} + 16'h0001);
  // shadows follow completed writes, so the line checks know mode and rate without peeking inside
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode    <= 2'h0;
      txinv   <= 1'b0;
      dbl     <= 1'b0;
      div     <= 12'h081;
      low_run <= 16'h0000;
    end else begin
      if (wr && pstrb[0] && paddr == `USP_ADDR_CONTROL)
        mode <= pwdata[7:6];
      if (wr && pstrb[0] && paddr == `USP_ADDR_DIVISOR)
        div[7:0] <= pwdata[7:0];
      if (wr && pstrb[1] && paddr == `USP_ADDR_DIVISOR)
        {dbl, txinv, div[11:8]} <= {pwdata[15], pwdata[13], pwdata[11:8]};
      low_run <= txd_out ? 16'h0000 : low_run + 16'h0001;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_ce: assert property (pready == ce)
    else $error("pready does not follow ce");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  chk_mask_quiet: assert property (wr && pstrb[0] && paddr == `USP_ADDR_INT_MASK && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with all sources masked");
  chk_sep_no_oe: assert property (mode[0] && $stable(mode) |-> !rxd_oe)
    else $error("shared pin driven in a two pin mode");
  chk_idle_tx: assert property (!mode[0] && $stable(mode) && $stable(txinv) |-> txd_out == !txinv)
    else $error("transmit pin not idle in a shared pin mode");
  chk_start_low: assert property ($rose(rxd_oe) |-> rxd_out == txinv)
    else $error("frame does not open with a start bit");
  chk_bit_time: assert property ($rose(txd_out) && !txinv && mode[0] |-> low_run % bt == 16'h0000)
    else $error("low run not a whole number of bit times");
  cover property ($rose(rxd_oe));
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule // usp_port_chk

bind usp_port usp_port_chk u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq)
);

// File: verification/usp_port_tb.sv
`timescale 1ns/1ps
`include "usp_defines.vh"
module usp_port_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         ce = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [3:0]  pstrb = 4'hF;
  reg         mode_sep = 1'b0;
  reg         rx_flip = 1'b0;
  reg         tx_flip = 1'b0;
  wire        pready, pslverr, rxd_out, rxd_oe, txd_out, irq, node_drv, rxd_in, line, node_in;
  wire [31:0] prdata;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     r, j, n0, nb;
  reg  [34:0] rows [0:3];
  reg  [1:0]  m;
  reg  [15:0] dv;
  reg  [8:0]  d, msk;
  reg  [7:0]  bt;
  always #4 pclk = ~pclk;
  // the shared line follows the port while it drives, else the node; the node idles high whenever it is not sending
  assign line    = rxd_oe ? rxd_out : node_drv;
  assign rxd_in  = (mode_sep ? node_drv : line) ^ rx_flip;
  assign node_in = mode_sep ? txd_out ^ tx_flip : line;
  usp_port DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
  usp_node node (.pclk(pclk), .line_in(node_in), .line_drv(node_drv));
  // ************************************************************
  // tasks
  // ************************************************************
  task give_verdict;
    begin
      if (n_errors == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input ok, input integer id);
    begin
      compares = compares + 1;
      if (ok !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t check %0d failed", $time, id);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] v, output [31:0] q, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    reg [31:0] q;
    reg        e;
    apb(1'b1, a, v, q, e);
  endtask
  task rc(input [11:0] a, input [31:0] k, input [31:0] x, input er);
    reg [31:0] q;
    reg        e;
    begin
      apb(1'b0, a, 32'h0, q, e);
      compares = compares + 1;
      if ((q & k) !== x || e !== er) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t read %h gave %h err %b", $time, a, q, e);
      end
    end
  endtask
  task wait_irq;
    integer k;
    begin
      for (k = 0; k < 2000 && irq !== 1'b1; k = k + 1)
        @(posedge pclk);
      chk(irq === 1'b1, 1);
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rows[0] = {2'h0, 16'h8001, 9'h0A5, 8'h10};
    rows[1] = {2'h1, 16'h0000, 9'h13C, 8'h10};
    rows[2] = {2'h2, 16'h8000, 9'h1C3, 8'h08};
    rows[3] = {2'h3, 16'h6001, 9'h05A, 8'h20};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (r = 0; r < 4; r = r + 1) begin
      {m, dv, d, bt} = rows[r];
      nb = 8 + m[1];
      msk = m[1] ? 9'h1FF : 9'h0FF;
      // receiver off first, so the polarity change below cannot look like a start bit
      wr(`USP_ADDR_CONTROL, 32'h0);
      mode_sep <= m[0];
      rx_flip <= dv[14];
      tx_flip <= dv[13];
      node.bclk = bt;
      node.nbits = nb;
      wr(`USP_ADDR_DIVISOR, {16'h0, dv});
      wr(`USP_ADDR_INT_MASK, 32'h3);
      wr(`USP_ADDR_CONTROL, {24'h0, m, 2'h1, d[8], 3'h0});
      n0 = node.n_got;
      wr(`USP_ADDR_DATA, {24'h0, d[7:0]});
      wait_irq;
      chk(node.n_got == n0 + 1 && ((node.got ^ d) & msk) == 9'h0, 2);
      rc(`USP_ADDR_INT_STATUS, 32'hFFFFFFFF, 32'h2, 1'b0);
      rc(`USP_ADDR_CONTROL, 32'h3, 32'h2, 1'b0);
      wr(`USP_ADDR_CONTROL, {24'h0, m, 2'h1, d[8], 3'h0});
      node.send(~d, nb);
      wait_irq;
      rc(`USP_ADDR_INT_STATUS, 32'hFFFFFFFF, 32'h1, 1'b0);
      rc(`USP_ADDR_DATA, 32'hFF, {24'h0, ~d[7:0]}, 1'b0);
      rc(`USP_ADDR_CONTROL, 32'h7, {29'h0, m[1] & ~d[8], 2'h1}, 1'b0);
    end
    chk(txd_out === 1'b0, 3);
    wr(`USP_ADDR_CONTROL, 32'h0);
    rx_flip <= 1'b0;
    tx_flip <= 1'b0;
    node.bclk = 16;
    wr(`USP_ADDR_DIVISOR, 32'h0);
    for (j = 0; j < 3; j = j + 1) begin
      wr(`USP_ADDR_CONTROL, j ? 32'hF0 : 32'h40);
      node.send(j == 2 ? 9'h133 : 9'h033, j ? 9 : 8);
      repeat (40) @(posedge pclk);
      rc(`USP_ADDR_INT_STATUS, 32'h3, j == 2 ? 32'h1 : 32'h0, 1'b0);
    end
    wr(`USP_ADDR_CONTROL, 32'h02);
    @(posedge pclk);
    chk(irq === 1'b1, 4);
    wr(`USP_ADDR_INT_MASK, 32'h0);
    @(posedge pclk);
    chk(irq === 1'b0, 5);
    rc(`USP_ADDR_INT_STATUS, 32'hFFFFFFFF, 32'h2, 1'b0);
    rc(`USP_ADDR_CONTROL, 32'h3, 32'h2, 1'b0);
    wr(`USP_ADDR_CONTROL, 32'h0);
    rc(`USP_ADDR_CONTROL, 32'h3, 32'h0, 1'b0);
    ce <= 1'b0;
    @(posedge pclk);
    chk(pready === 1'b0, 6);
    repeat (2) @(posedge pclk);
    ce <= 1'b1;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(`USP_ADDR_CONTROL, 32'hFFFFFFFF, 32'h0, 1'b0);
    rc(`USP_ADDR_DIVISOR, 32'hFFFFFFFF, 32'h81, 1'b0);
    rc(`USP_ADDR_INT_MASK, 32'hFFFFFFFF, 32'h0, 1'b0);
    rc(`USP_ADDR_INT_STATUS, 32'hFFFFFFFF, 32'h0, 1'b0);
    rc(12'h26C, 32'h0, 32'h0, 1'b1);
    give_verdict;
  end
endmodule // usp_port_tb
